// >>> pfm_pkg.sv
// shared constants and types for the port pin function mux
package pfm_pkg;

  localparam int PFM_DW   = 8;
  localparam int PFM_AW   = 4;
  localparam int PFM_PA_N = 4;
  localparam int PFM_PB_N = 2;
  localparam int PFM_LF_N = 2;

  // register offsets
  localparam logic [3:0] PFM_A_PA_DATA  = 4'h0;
  localparam logic [3:0] PFM_A_PA_DIR   = 4'h1;
  localparam logic [3:0] PFM_A_PA_PULL  = 4'h2;
  localparam logic [3:0] PFM_A_PA_PDSEL = 4'h3;
  localparam logic [3:0] PFM_A_WAKE_EN  = 4'h4;
  localparam logic [3:0] PFM_A_WAKE_FLG = 4'h5;
  localparam logic [3:0] PFM_A_PA_IN    = 4'h6;
  localparam logic [3:0] PFM_A_PB_DATA  = 4'h7;
  localparam logic [3:0] PFM_A_PB_DIR   = 4'h8;
  localparam logic [3:0] PFM_A_PB_PULL  = 4'h9;
  localparam logic [3:0] PFM_A_PB_FUNC  = 4'hA;
  localparam logic [3:0] PFM_A_PB_IN    = 4'hB;
  localparam logic [3:0] PFM_A_MODE     = 4'hC;

  // reset values
  localparam logic [3:0] PFM_RST_PA   = 4'h0;
  localparam logic [1:0] PFM_RST_PB   = 2'h0;
  localparam logic [3:0] PFM_RST_FUNC = 4'h0;
  localparam logic [2:0] PFM_RST_MODE = 3'h0;
  localparam logic [7:0] PFM_RD_ZERO  = 8'h00;

  // mode register bits
  localparam int PFM_MODE_W   = 3;
  localparam int PFM_MODE_SPI = 0;
  localparam int PFM_MODE_IRQ = 1;
  localparam int PFM_MODE_LF  = 2;

  // port A pin roles while the serial interface is on
  localparam int PFM_PIN_SS   = 0;
  localparam int PFM_PIN_SCLK = 1;
  localparam int PFM_PIN_MISO = 2;
  localparam int PFM_PIN_MOSI = 3;

  // port B function field positions
  localparam int PFM_PB0_LSB = 0;
  localparam int PFM_PB1_LSB = 2;
  localparam int PFM_FUNC_W  = 2;

  // low-frequency input indices
  localparam int PFM_LF_POS = 0;
  localparam int PFM_LF_NEG = 1;

  typedef enum logic [1:0] {
    PFM_PB_GPIO  = 2'b00,
    PFM_PB_TIMER = 2'b01,
    PFM_PB_CONV  = 2'b10
  } pfm_pbfunc_t;

endpackage

// >>> pfm_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pfm_sync
  import pfm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds only the second flop
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// >>> pfm_pad_cell.sv
// registered pad controls for a group of pins
`timescale 1ns/1ns
module pfm_pad_cell
  import pfm_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] next_out,
  input  wire logic [WIDTH-1:0] next_oe,
  input  wire logic [WIDTH-1:0] next_pullUp,
  input  wire logic [WIDTH-1:0] next_pullDown,
  output logic      [WIDTH-1:0] padOut,
  output logic      [WIDTH-1:0] padOe,
  output logic      [WIDTH-1:0] padPullUp,
  output logic      [WIDTH-1:0] padPullDown
);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      padOut      <= '0;
      padOe       <= '0;
      padPullUp   <= '0;
      padPullDown <= '0;
    end else begin
      padOut      <= next_out;
      padOe       <= next_oe;
      padPullUp   <= next_pullUp & ~next_pullDown;
      padPullDown <= next_pullDown;
    end
  end

  pull_exclusive_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    (padPullUp & padPullDown) == '0)
    else $error("pullup and pulldown both on");

endmodule

// >>> pfm_port_mux.sv
// pin function mux for port A, port B and the low-frequency inputs
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module pfm_port_mux
  import pfm_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic [PFM_AW-1:0]   regAddr,
  input  wire logic [PFM_DW-1:0]   regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [PFM_DW-1:0]   regRdata,
  input  wire logic [PFM_PA_N-1:0] port_a_pin_in,
  output logic      [PFM_PA_N-1:0] port_a_pin_out,
  output logic      [PFM_PA_N-1:0] port_a_pin_oe,
  output logic      [PFM_PA_N-1:0] port_a_pin_pullUp,
  output logic      [PFM_PA_N-1:0] port_a_pin_pullDown,
  input  wire logic [PFM_PB_N-1:0] port_b_pin_in,
  output logic      [PFM_PB_N-1:0] port_b_pin_out,
  output logic      [PFM_PB_N-1:0] port_b_pin_oe,
  output logic      [PFM_PB_N-1:0] port_b_pin_pullUp,
  input  wire logic                lowfreqInputPos,
  input  wire logic                lowfreqInputNeg,
  output logic [PFM_PA_N-1:0]      keyboardWakeInterrupt,
  output logic                     extIrqN,
  output logic                     spiEnable,
  output logic                     spiSclk,
  output logic                     spiMosi,
  output logic                     spiSelectN,
  input  wire logic                spiMiso,
  input  wire logic                spiMisoOe,
  input  wire logic                timerCh0Out,
  input  wire logic                timerCh0Oe,
  input  wire logic                timerCh1Out,
  input  wire logic                timerCh1Oe,
  output logic                     timerCh0In,
  output logic                     timerCh1In,
  output logic                     converterInputCh3Sel,
  output logic                     converterInputCh4Sel,
  output logic                     lowfreqReceiverEnable,
  output logic                     lowfreqReceiverPos,
  output logic                     lowfreqReceiverNeg
);

  // software state
  logic [PFM_PA_N-1:0]   portAData;
  logic [PFM_PA_N-1:0]   portADir;
  logic [PFM_PA_N-1:0]   portAPullEn;
  logic [PFM_PA_N-1:0]   portAPullDownSel;
  logic [PFM_PA_N-1:0]   wakeEnable;
  logic [PFM_PA_N-1:0]   wakeFlag;
  logic [PFM_PB_N-1:0]   portBData;
  logic [PFM_PB_N-1:0]   portBDir;
  logic [PFM_PB_N-1:0]   portBPullEn;
  logic [PFM_PB_N*PFM_FUNC_W-1:0] portBFunc;
  logic [PFM_MODE_W-1:0] mode;

  // synchronised pins and edge history
  logic [PFM_PA_N-1:0]   pinASync;
  logic [PFM_PA_N-1:0]   pinAPrev;
  logic [PFM_PB_N-1:0]   pinBSync;
  logic [PFM_LF_N-1:0]   lfSync;

  // next pad values
  logic [PFM_PA_N-1:0]   next_aOut;
  logic [PFM_PA_N-1:0]   next_aOe;
  logic [PFM_PA_N-1:0]   next_aPullUp;
  logic [PFM_PA_N-1:0]   next_aPullDown;
  logic [PFM_PB_N-1:0]   next_bOut;
  logic [PFM_PB_N-1:0]   next_bOe;
  logic [PFM_PB_N-1:0]   next_bPullUp;
  logic [PFM_PA_N-1:0]   wakeActive;
  logic [PFM_PA_N-1:0]   wakeEdge;
  logic                  spiOn;
  logic                  irqOn;
  pfm_pbfunc_t           pb0Func;
  pfm_pbfunc_t           pb1Func;

  // decode a port B function field; reserved code falls back to GPIO
  function automatic pfm_pbfunc_t pbFuncOf(input logic [1:0] code);
    pfm_pbfunc_t f;
    f = PFM_PB_GPIO;
    unique case (code)
      PFM_PB_TIMER: f = PFM_PB_TIMER;
      PFM_PB_CONV:  f = PFM_PB_CONV;
      default:      f = PFM_PB_GPIO;
    endcase
    return f;
  endfunction

  // drive of one port B pin: {oe, out}
  function automatic logic [1:0] pbDrive(input pfm_pbfunc_t f,
                                         input logic data,
                                         input logic dir,
                                         input logic tOut,
                                         input logic tOe);
    logic [1:0] d;
    d = {dir, data};
    unique case (f)
      PFM_PB_TIMER: d = {tOe, tOut};
      // analog path: digital driver must stay off
      PFM_PB_CONV:  d = 2'h0;
      PFM_PB_GPIO:  d = {dir, data};
    endcase
    return d;
  endfunction

  assign spiOn   = mode[PFM_MODE_SPI];
  assign irqOn   = mode[PFM_MODE_IRQ];
  assign pb0Func = pbFuncOf(portBFunc[PFM_PB0_LSB +: PFM_FUNC_W]);
  assign pb1Func = pbFuncOf(portBFunc[PFM_PB1_LSB +: PFM_FUNC_W]);

  pfm_sync #(.WIDTH(PFM_PA_N)) syncA (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (port_a_pin_in),
    .syncOut (pinASync)
  );

  pfm_sync #(.WIDTH(PFM_PB_N)) syncB (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (port_b_pin_in),
    .syncOut (pinBSync)
  );

  pfm_sync #(.WIDTH(PFM_LF_N)) syncLf (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn ({lowfreqInputNeg, lowfreqInputPos}),
    .syncOut (lfSync)
  );

  // register writes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      portAData        <= PFM_RST_PA;
      portADir         <= PFM_RST_PA;
      portAPullEn      <= PFM_RST_PA;
      portAPullDownSel <= PFM_RST_PA;
      wakeEnable       <= PFM_RST_PA;
      portBData        <= PFM_RST_PB;
      portBDir         <= PFM_RST_PB;
      portBPullEn      <= PFM_RST_PB;
      portBFunc        <= PFM_RST_FUNC;
      mode             <= PFM_RST_MODE;
    end else if (regWrite) begin
      unique case (regAddr)
        PFM_A_PA_DATA:  portAData   <= regWdata[PFM_PA_N-1:0];
        PFM_A_PA_DIR:   portADir    <= regWdata[PFM_PA_N-1:0];
        PFM_A_PA_PULL:  portAPullEn <= regWdata[PFM_PA_N-1:0];
        PFM_A_PA_PDSEL: portAPullDownSel <= regWdata[PFM_PA_N-1:0];
        PFM_A_WAKE_EN:  wakeEnable  <= regWdata[PFM_PA_N-1:0];
        PFM_A_PB_DATA:  portBData   <= regWdata[PFM_PB_N-1:0];
        PFM_A_PB_DIR:   portBDir    <= regWdata[PFM_PB_N-1:0];
        PFM_A_PB_PULL:  portBPullEn <= regWdata[PFM_PB_N-1:0];
        PFM_A_PB_FUNC:
          portBFunc <= regWdata[PFM_PB_N*PFM_FUNC_W-1:0];
        PFM_A_MODE:     mode        <= regWdata[PFM_MODE_W-1:0];
        default: ;
      endcase
    end
  end

  // wake request level: high level with pulldown, low level with pullup
  assign wakeActive = wakeEnable & ~(pinASync ^ portAPullDownSel);
  // edge only when the previous sample was at the idle level
  assign wakeEdge   = wakeActive & (pinAPrev ^ portAPullDownSel);

  // sticky wake flags, write one to clear; a new edge beats the clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pinAPrev <= PFM_RST_PA;
      wakeFlag <= PFM_RST_PA;
    end else begin
      pinAPrev <= pinASync;
      if (regWrite && regAddr == PFM_A_WAKE_FLG) begin
        wakeFlag <= (wakeFlag & ~regWdata[PFM_PA_N-1:0]) | wakeEdge;
      end else begin
        wakeFlag <= wakeFlag | wakeEdge;
      end
    end
  end

  // read port, data valid the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      regRdata <= PFM_RD_ZERO;
    end else if (regRead) begin
      regRdata <= PFM_RD_ZERO;
      unique case (regAddr)
        PFM_A_PA_DATA:  regRdata[PFM_PA_N-1:0] <= portAData;
        PFM_A_PA_DIR:   regRdata[PFM_PA_N-1:0] <= portADir;
        PFM_A_PA_PULL:  regRdata[PFM_PA_N-1:0] <= portAPullEn;
        PFM_A_PA_PDSEL: regRdata[PFM_PA_N-1:0] <= portAPullDownSel;
        PFM_A_WAKE_EN:  regRdata[PFM_PA_N-1:0] <= wakeEnable;
        PFM_A_WAKE_FLG: regRdata[PFM_PA_N-1:0] <= wakeFlag;
        PFM_A_PA_IN:    regRdata[PFM_PA_N-1:0] <= pinASync;
        PFM_A_PB_DATA:  regRdata[PFM_PB_N-1:0] <= portBData;
        PFM_A_PB_DIR:   regRdata[PFM_PB_N-1:0] <= portBDir;
        PFM_A_PB_PULL:  regRdata[PFM_PB_N-1:0] <= portBPullEn;
        PFM_A_PB_FUNC:
          regRdata[PFM_PB_N*PFM_FUNC_W-1:0] <= portBFunc;
        PFM_A_PB_IN:    regRdata[PFM_PB_N-1:0] <= pinBSync;
        PFM_A_MODE:     regRdata[PFM_MODE_W-1:0] <= mode;
        default: ;
      endcase
    end else begin
      regRdata <= PFM_RD_ZERO;
    end
  end

  // port A pad selection
  always_comb begin
    next_aOut      = portAData;
    next_aOe       = portADir;
    next_aPullUp   = portAPullEn & ~portAPullDownSel;
    // pulldown is gated by the wake enable of the same pin
    next_aPullDown = portAPullEn & portAPullDownSel & wakeEnable;
    if (irqOn) begin
      next_aOe[PFM_PIN_SS] = 1'b0;
    end
    if (spiOn) begin
      // serial roles win over direction and data bits
      next_aOe                = '0;
      next_aOe[PFM_PIN_MISO]  = spiMisoOe;
      next_aOut[PFM_PIN_MISO] = spiMiso;
    end
  end

  // port B pad selection
  always_comb begin
    {next_bOe[0], next_bOut[0]} =
      pbDrive(pb0Func, portBData[0], portBDir[0],
              timerCh0Out, timerCh0Oe);
    {next_bOe[1], next_bOut[1]} =
      pbDrive(pb1Func, portBData[1], portBDir[1],
              timerCh1Out, timerCh1Oe);
    next_bPullUp[0] = portBPullEn[0] && pb0Func != PFM_PB_CONV;
    next_bPullUp[1] = portBPullEn[1] && pb1Func != PFM_PB_CONV;
  end

  pfm_pad_cell #(.WIDTH(PFM_PA_N)) padA (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .next_out      (next_aOut),
    .next_oe       (next_aOe),
    .next_pullUp   (next_aPullUp),
    .next_pullDown (next_aPullDown),
    .padOut        (port_a_pin_out),
    .padOe         (port_a_pin_oe),
    .padPullUp     (port_a_pin_pullUp),
    .padPullDown   (port_a_pin_pullDown)
  );

  pfm_pad_cell #(.WIDTH(PFM_PB_N)) padB (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .next_out      (next_bOut),
    .next_oe       (next_bOe),
    .next_pullUp   (next_bPullUp),
    .next_pullDown ({PFM_PB_N{1'b0}}),
    .padOut        (port_b_pin_out),
    .padOe         (port_b_pin_oe),
    .padPullUp     (port_b_pin_pullUp),
    .padPullDown   ()
  );

  // inputs toward peripherals
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      keyboardWakeInterrupt <= PFM_RST_PA;
      extIrqN               <= 1'b1;
    end else begin
      keyboardWakeInterrupt <= wakeActive;
      // select role of pin 0 takes it away from the interrupt request
      extIrqN <= (irqOn && !spiOn) ? pinASync[PFM_PIN_SS] : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      spiEnable  <= 1'b0;
      spiSclk    <= 1'b0;
      spiMosi    <= 1'b0;
      spiSelectN <= 1'b1;
    end else begin
      spiEnable  <= spiOn;
      spiSclk    <= spiOn & pinASync[PFM_PIN_SCLK];
      spiMosi    <= spiOn & pinASync[PFM_PIN_MOSI];
      // idle deselected so the serial block ignores a disabled pin
      spiSelectN <= spiOn ? pinASync[PFM_PIN_SS] : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      timerCh0In           <= 1'b0;
      timerCh1In           <= 1'b0;
      converterInputCh3Sel <= 1'b0;
      converterInputCh4Sel <= 1'b0;
    end else begin
      timerCh0In           <= (pb0Func == PFM_PB_TIMER) & pinBSync[0];
      timerCh1In           <= (pb1Func == PFM_PB_TIMER) & pinBSync[1];
      converterInputCh3Sel <= (pb0Func == PFM_PB_CONV);
      converterInputCh4Sel <= (pb1Func == PFM_PB_CONV);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      lowfreqReceiverEnable <= 1'b0;
      lowfreqReceiverPos    <= 1'b0;
      lowfreqReceiverNeg    <= 1'b0;
    end else begin
      lowfreqReceiverEnable <= mode[PFM_MODE_LF];
      lowfreqReceiverPos    <= mode[PFM_MODE_LF] & lfSync[PFM_LF_POS];
      lowfreqReceiverNeg    <= mode[PFM_MODE_LF] & lfSync[PFM_LF_NEG];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  pulldown_wake_gate_a: assert property (
    (port_a_pin_pullDown & ~$past(wakeEnable)) == 4'h0)
    else $error("pulldown on without wake enable");

  kbi_route_a: assert property (
    $past(wakeEnable[0] & portAPullDownSel[0] & pinASync[0])
    |-> keyboardWakeInterrupt[0])
    else $error("pin 0 level not routed to wake bit 0");

  spi_mosi_a: assert property (
    $past(spiOn) |-> spiMosi == $past(pinASync[PFM_PIN_MOSI])
                     && !port_a_pin_oe[PFM_PIN_MOSI])
    else $error("mosi pin not routed");

  spi_miso_a: assert property (
    $past(spiOn) |-> port_a_pin_oe[PFM_PIN_MISO] == $past(spiMisoOe)
                 && port_a_pin_out[PFM_PIN_MISO] == $past(spiMiso))
    else $error("miso pin not driven by serial block");

  spi_sclk_a: assert property (
    $past(spiOn) |-> spiSclk == $past(pinASync[PFM_PIN_SCLK])
                     && !port_a_pin_oe[PFM_PIN_SCLK])
    else $error("serial clock pin not routed");

  spi_select_a: assert property (
    !$past(spiOn) |-> spiSelectN)
    else $error("select active while serial off");

  ext_irq_a: assert property (
    $past(irqOn) && !$past(spiOn) |-> !port_a_pin_oe[PFM_PIN_SS]
                   && extIrqN == $past(pinASync[PFM_PIN_SS]))
    else $error("interrupt pin not an input");

  pb1_conv_a: assert property (
    $past(pb1Func == PFM_PB_CONV) |-> converterInputCh4Sel
                                  && !port_b_pin_oe[1])
    else $error("port b pin 1 converter mode wrong");

  pb0_timer_a: assert property (
    $past(pb0Func == PFM_PB_TIMER) |-> port_b_pin_oe[0] == $past(timerCh0Oe)
                                   && !converterInputCh3Sel)
    else $error("port b pin 0 timer mode wrong");

  lowfreq_gate_a: assert property (
    !$past(mode[PFM_MODE_LF]) |-> !lowfreqReceiverPos && !lowfreqReceiverNeg)
    else $error("coil input passed while receiver off");

endmodule

// >>> pfm_pin_partner.sv
// board-side pad model for the port pin function mux
`timescale 1ns/1ns
module pfm_pin_partner
  import pfm_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic [PFM_PA_N-1:0] aOut,
  input  wire logic [PFM_PA_N-1:0] aOe,
  input  wire logic [PFM_PA_N-1:0] aPullUp,
  input  wire logic [PFM_PA_N-1:0] aPullDown,
  input  wire logic [PFM_PA_N-1:0] aExtEn,
  input  wire logic [PFM_PA_N-1:0] aExtVal,
  input  wire logic [PFM_PB_N-1:0] bOut,
  input  wire logic [PFM_PB_N-1:0] bOe,
  input  wire logic [PFM_PB_N-1:0] bPullUp,
  input  wire logic [PFM_PB_N-1:0] bExtEn,
  input  wire logic [PFM_PB_N-1:0] bExtVal,
  output logic      [PFM_PA_N-1:0] aPin,
  output logic      [PFM_PB_N-1:0] bPin
);
  logic wander;

  // an unheld pin flips every cycle, so a missing pull cannot hide
  initial wander = 1'h0;
  always @(posedge sys_clk) wander <= ~wander;

  function automatic logic level(input logic oe, input logic out,
                                 input logic en, input logic val,
                                 input logic pu, input logic pd);
    if (oe) return out;
    if (en) return val;
    if (pu) return 1'h1;
    if (pd) return 1'h0;
    return wander;
  endfunction

  always_comb begin
    for (int i = 0; i < PFM_PA_N; i++) begin
      aPin[i] = level(aOe[i], aOut[i], aExtEn[i], aExtVal[i],
                      aPullUp[i], aPullDown[i]);
    end
    for (int i = 0; i < PFM_PB_N; i++) begin
      bPin[i] = level(bOe[i], bOut[i], bExtEn[i], bExtVal[i],
                      bPullUp[i], 1'h0);
    end
  end
endmodule

// >>> pfm_port_mux_bench.sv
// self-checking bench for the port pin function mux
`timescale 1ns/1ns
module pfm_port_mux_bench
  import pfm_pkg::*;
();
  localparam logic [3:0] RW_LIST [10] = '{PFM_A_PA_DATA, PFM_A_PA_DIR,
    PFM_A_PA_PULL, PFM_A_PA_PDSEL, PFM_A_WAKE_EN, PFM_A_PB_DATA,
    PFM_A_PB_DIR, PFM_A_PB_PULL, PFM_A_PB_FUNC, PFM_A_MODE};
  logic                sys_clk, reset_n, regWrite, regRead;
  logic [PFM_AW-1:0]   regAddr;
  logic [PFM_DW-1:0]   regWdata, regRdata, d, w, rdv, m, got;
  logic [PFM_PA_N-1:0] aPin, aOut, aOe, aPullUp, aPullDown, kwi;
  logic [PFM_PA_N-1:0] aExtEn, aExtVal;
  logic [PFM_PB_N-1:0] bPin, bOut, bOe, bPullUp, bExtEn, bExtVal;
  logic                lfPos, lfNeg, extIrqN, spiEnable, spiSclk, spiMosi;
  logic                spiSelectN, spiMiso, spiMisoOe, t0Out, t0Oe;
  logic                t1Out, t1Oe, t0In, t1In, conv3, conv4;
  logic                lowfreq_receiver_enable, lfRxPos, lfRxNeg;
  int                  n_mismatch, compares, cycles;
  integer              seed;

  pfm_port_mux u_pfm_port_mux (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .port_a_pin_in(aPin),
    .port_a_pin_out(aOut), .port_a_pin_oe(aOe),
    .port_a_pin_pullUp(aPullUp), .port_a_pin_pullDown(aPullDown),
    .port_b_pin_in(bPin), .port_b_pin_out(bOut), .port_b_pin_oe(bOe),
    .port_b_pin_pullUp(bPullUp), .lowfreqInputPos(lfPos),
    .lowfreqInputNeg(lfNeg), .keyboardWakeInterrupt(kwi),
    .extIrqN(extIrqN), .spiEnable(spiEnable), .spiSclk(spiSclk),
    .spiMosi(spiMosi), .spiSelectN(spiSelectN), .spiMiso(spiMiso),
    .spiMisoOe(spiMisoOe), .timerCh0Out(t0Out), .timerCh0Oe(t0Oe),
    .timerCh1Out(t1Out), .timerCh1Oe(t1Oe), .timerCh0In(t0In),
    .timerCh1In(t1In), .converterInputCh3Sel(conv3),
    .converterInputCh4Sel(conv4), .lowfreqReceiverEnable(lowfreq_receiver_enable),
    .lowfreqReceiverPos(lfRxPos), .lowfreqReceiverNeg(lfRxNeg));

  pfm_pin_partner u_pfm_pin_partner (.sys_clk(sys_clk), .aOut(aOut),
    .aOe(aOe), .aPullUp(aPullUp), .aPullDown(aPullDown),
    .aExtEn(aExtEn), .aExtVal(aExtVal), .bOut(bOut), .bOe(bOe),
    .bPullUp(bPullUp), .bExtEn(bExtEn), .bExtVal(bExtVal),
    .aPin(aPin), .bPin(bPin));

  function automatic logic [7:0] wmask(input logic [3:0] a);
    case (a)
      PFM_A_PB_DATA, PFM_A_PB_DIR, PFM_A_PB_PULL: return 8'h03;
      PFM_A_MODE: return 8'h07;
      default: return 8'h0F;
    endcase
  endfunction

  function automatic logic [7:0] pullExp(input logic [3:0] pl,
      input logic [3:0] sl, input logic [3:0] wk);
    return {pl & ~sl, pl & sl & wk};
  endfunction

  // bits: oe, out, pullup, converter select, timer input
  function automatic logic [7:0] pbExp(input int f, input logic dat,
                                       input logic tOut);
    case (f)
      1: return {3'h0, 1'h1, tOut, 1'h1, 1'h0, tOut};
      2: return 8'h02;
      default: return {3'h0, 1'h1, dat, 1'h1, 2'h0};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'h1;
    @(posedge sys_clk);
    regWrite <= 1'h0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge sys_clk);
    regRead <= 1'h0;
    #1 v = regRdata;
    @(posedge sys_clk);
  endtask

  // pin to peripheral takes three edges, so five covers it with margin
  task automatic settle;
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    seed = 32'h4282;
    {reset_n, regWrite, regRead, regAddr, regWdata} = '0;
    {lfPos, lfNeg, spiMiso, spiMisoOe, t0Out, t0Oe, t1Out, t1Oe} = '0;
    {aExtVal, bExtVal, n_mismatch, compares, cycles} = '0;
    aExtEn = 4'hF;
    bExtEn = 2'h3;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'h1;
    settle();
    chk("reset_idle", 8'h03, 8'({extIrqN, spiSelectN}));
    chk("reset_pads", 8'h00, {aOe, aOut});
    chk("reset_pulls", 8'h00, {aPullUp, aPullDown});
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), rdv);
      chk("reset_reg", 8'h00, rdv);
    end
    aExtVal <= 4'hA;
    bExtVal <= 2'h2;
    settle();
    for (int a = 6; a < 16; a++) begin
      if (a != 6 && a != 11 && a < 13) continue;
      wr(4'(a), 8'hFF);
      rd(4'(a), rdv);
      chk("ro_unmapped", a == 6 ? 8'h0A : a == 11 ? 8'h02 : 8'h00,
          rdv);
    end
    $display("test reset_and_map done");
    for (int i = 0; i < 20; i++) begin
      m = RW_LIST[$unsigned($random(seed)) % 10];
      d = 8'($random(seed));
      wr(m[3:0], d);
      rd(m[3:0], rdv);
      chk("reg_rw", d & wmask(m[3:0]), rdv);
    end
    for (int i = 0; i < 10; i++) wr(RW_LIST[i], 8'h00);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      w = 8'($random(seed));
      if (i == 0) begin
        d = 8'hFF;
        w = 8'h00;
      end
      wr(PFM_A_PA_PULL, 8'(d[3:0]));
      wr(PFM_A_PA_PDSEL, 8'(d[7:4]));
      wr(PFM_A_WAKE_EN, 8'(w[3:0]));
      settle();
      chk("pulls", pullExp(d[3:0], d[7:4], w[3:0]),
          {aPullUp, aPullDown});
    end
    $display("test pulls done");
    wr(PFM_A_PA_PULL, 8'h0F);
    wr(PFM_A_WAKE_EN, 8'h0F);
    for (int s = 0; s < 2; s++) begin
      wr(PFM_A_PA_PDSEL, s ? 8'h0F : 8'h00);
      for (int n = 0; n < 4; n++) begin
        aExtVal <= s ? 4'(1 << n) : ~4'(1 << n);
        settle();
        chk("wake", 8'(1 << n), 8'(kwi));
      end
    end
    // sticky flag: set on a rising active edge, not re-set by a held level
    aExtVal <= 4'h0;
    settle();
    wr(PFM_A_WAKE_FLG, 8'h0F);
    aExtVal <= 4'h2;
    settle();
    rd(PFM_A_WAKE_FLG, rdv);
    chk("flag_set", 8'h02, rdv);
    wr(PFM_A_WAKE_FLG, 8'h0F);
    rd(PFM_A_WAKE_FLG, rdv);
    chk("flag_clear", 8'h00, rdv);
    wr(PFM_A_PA_PDSEL, 8'h00);
    wr(PFM_A_WAKE_EN, 8'h00);
    settle();
    chk("wake_off", 8'h00, 8'(kwi));
    $display("test wake done");
    wr(PFM_A_PA_DIR, 8'h0F);
    wr(PFM_A_PA_DATA, 8'h0F);
    aExtEn <= 4'hB;
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(PFM_A_MODE, i[0] ? 8'h03 : 8'h01);
      aExtVal <= d[3:0];
      spiMiso <= d[4];
      spiMisoOe <= d[5];
      settle();
      chk("spi_in", 8'({d[3], d[1], d[0]}),
          8'({spiMosi, spiSclk, spiSelectN}));
      chk("spi_oe", 8'({1'h0, d[5], 2'h0}), 8'(aOe));
      chk("miso_out", 8'(d[4]), 8'(aOut[PFM_PIN_MISO]));
      chk("spi_irq", 8'h03, 8'({spiEnable, extIrqN}));
    end
    wr(PFM_A_MODE, 8'h00);
    aExtEn <= 4'h0;
    settle();
    chk("spi_idle", 8'h01,
        8'({spiEnable, spiMosi, spiSclk, spiSelectN}));
    chk("gpio_pads", 8'hFF, {aOe, aOut});
    wr(PFM_A_MODE, 8'h02);
    aExtEn <= 4'h1;
    for (int v = 0; v < 2; v++) begin
      aExtVal <= 4'(v);
      settle();
      chk("irq", 8'(v), 8'(extIrqN));
      chk("irq_oe", 8'h0E, 8'(aOe));
    end
    wr(PFM_A_MODE, 8'h00);
    $display("test serial_and_irq done");
    wr(PFM_A_PB_DIR, 8'h03);
    wr(PFM_A_PB_PULL, 8'h03);
    bExtEn <= 2'h0;
    for (int i = 0; i < 2; i++) begin
      for (int f = 0; f < 4; f++) begin
        d = 8'($random(seed));
        wr(PFM_A_PB_DATA, 8'(d[1:0]));
        wr(PFM_A_PB_FUNC, 8'(f << (2 * i)));
        t0Out <= d[2];
        t1Out <= d[2];
        t0Oe <= 1'h1;
        t1Oe <= 1'h1;
        settle();
        // converter drive level and timer pullup are left open
        m = (f == 2) ? 8'h17 : (f == 1) ? 8'h1B : 8'h1F;
        got = {3'h0, bOe[i], bOut[i], bPullUp[i], i ? conv4 : conv3,
               i ? t1In : t0In};
        chk("pb_func", pbExp(f, d[i], d[2]) & m, got & m);
      end
    end
    $display("test port_b done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h03 : 8'($random(seed));
      wr(PFM_A_MODE, 8'({d[2], 2'h0}));
      lfPos <= d[0];
      lfNeg <= d[1];
      settle();
      chk("lowfreq", 8'({d[2], d[1] & d[2], d[0] & d[2]}),
          8'({lowfreq_receiver_enable, lfRxNeg, lfRxPos}));
    end
    $display("test lowfreq done");
    end_of_test();
  end
endmodule
